// ---- design/tclc_consts.vh ----
// Constants for the temperature conversion and limit control block
`ifndef TCLC_CONSTS_VH
`define TCLC_CONSTS_VH
// Register addresses
`define TCLC_A_LOC_TEMP      8'h00
`define TCLC_A_R1_TEMP_HI    8'h01
`define TCLC_A_CFG_RD        8'h03
`define TCLC_A_RATE_RD       8'h04
`define TCLC_A_CFG_WR        8'h09
`define TCLC_A_RATE_WR       8'h0A
`define TCLC_A_R1_TEMP_LO    8'h10
`define TCLC_A_R2_TEMP_HI    8'h30
`define TCLC_A_R2_TEMP_LO    8'h33
`define TCLC_A_LIM_BASE      8'h40
`define TCLC_A_LIM_LAST      8'h4C
`define TCLC_A_HYST          8'h4D
// Limit slot indices, offset from the limit base
`define TCLC_L_LOC_HI        4'h0
`define TCLC_L_LOC_LO        4'h1
`define TCLC_L_LOC_OT        4'h2
`define TCLC_L_R1_HI_H       4'h3
`define TCLC_L_R1_HI_L       4'h4
`define TCLC_L_R1_LO_H       4'h5
`define TCLC_L_R1_LO_L       4'h6
`define TCLC_L_R1_OT         4'h7
`define TCLC_L_R2_HI_H       4'h8
`define TCLC_L_R2_HI_L       4'h9
`define TCLC_L_R2_LO_H       4'hA
`define TCLC_L_R2_LO_L       4'hB
`define TCLC_L_R2_OT         4'hC
// Reset values
`define TCLC_RATE_RST        8'h08
`define TCLC_CFG_RST         8'h00
`define TCLC_HYST_RST        8'h0A
`define TCLC_HI_RST          8'h7F
`define TCLC_LO_RST          8'h00
`define TCLC_OT_RST          8'h7F
// Field positions
`define TCLC_RATE_AVG_OFF    7
`define TCLC_RATE_CH_HI      5
`define TCLC_RATE_CH_LO      4
`define TCLC_RATE_CODE_HI    3
`define TCLC_CFG_PIN_SEL     5
`define TCLC_CFG_RANGE       2
// Rate codes and channel selection
`define TCLC_CODE_FASTEST    4'hA
`define TCLC_CODE_CONT       4'hB
`define TCLC_CODE_NO_AVG     4'h8
`define TCLC_CODE_RST        4'h8
`define TCLC_SEL_ALL         2'h0
`define TCLC_SEL_LOCAL       2'h1
`define TCLC_SEL_R1          2'h2
`define TCLC_SEL_R2          2'h3
`define TCLC_CH_LOCAL        2'h0
`define TCLC_CH_R1           2'h1
`define TCLC_CH_R2           2'h2
// Timing: base tick is the shortest interval, 1/64 s
`define TCLC_TICK_NS         15625000
`define TCLC_CLK_NS          40
`endif

// ---- design/tclc_conversion_limit_control.v ----
// Conversion scheduler, limit registers and over-temperature outputs
`timescale 1ns/100ps
// Function
// - Rate bits 3:0 code n from zero to ten gives 0.0625 times 2^n conversions per second.
// - Code eleven converts back to back with no idle time.
// - Rate and channel register resets to 0x08: sixteen per second, round robin.
// - Each interval start converts every enabled channel.
// - Bit 7 clear enables averaging; rate codes eight to ten never average.
// - Bits 5:4 pick round robin, local, first remote or second remote only.
// - Rate register reads at 0x04, writes at 0x0A, reads back unchanged.
// - Three channels each have high, low, over-temperature limits; remote high and low limits two bytes.
// - High flag set only when measurement strictly above high limit.
// - Low flag set when measurement at or below low limit.
// - Any channel above its over-temperature limit drives overtemp output low.
// - Second overtemp output low when any channel's whole-degree byte exceeds the high byte of its high limit.
// - One hysteresis value, reset 10, serves both overtemp outputs.
// - Limits compared raw in current format; never converted on range change.
// - All limit and hysteresis registers writable and read back.
// - Overtemp output releases only below limit minus hysteresis.
// - Config bit 5 selects shared pin: alert when clear, second overtemp when set.
// - Extended range data is offset binary, value plus 64.
`include "tclc_consts.vh"

module tclc_conversion_limit_control
#(
  parameter TICK_CYCLES = `TCLC_TICK_NS / `TCLC_CLK_NS
)
(
  input  wire        clock,
  input  wire        nrst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         adc_start,
  output reg  [1:0]  adc_channel,
  output reg         adc_average,
  output wire        adc_extended_range,
  input  wire        adc_done,
  input  wire [15:0] adc_result,
  output reg         conv_busy,
  output reg  [2:0]  high_flags,
  output reg  [2:0]  low_flags,
  output wire        overtemp_out_n,
  output wire        second_overtemp_out_n,
  output wire        shared_pin_function_select
);

  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg  [7:0]  rate_reg;
  reg  [7:0]  cfg_reg;
  reg  [7:0]  hyst_reg;
  reg  [7:0]  lim [0:12];
  reg  [15:0] meas [0:2];
  reg  [2:0]  ot_state;
  reg  [2:0]  ot2_state;
  reg  [31:0] pre_cnt;
  reg  [9:0]  tick_cnt;
  reg  [3:0]  act_code;
  reg  [1:0]  act_sel;
  reg         act_avg_off;
  reg  [1:0]  state;
  reg  [1:0]  cur_ch;
  wire        tick;
  wire [9:0]  ticks_per_iv;
  wire        boundary;
  wire        cont_mode;
  wire [3:0]  lim_idx;
  wire        lim_hit;
  integer     i;
  integer     j;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and reads
  assign lim_idx = reg_addr[3:0];
  assign lim_hit = (reg_addr >= `TCLC_A_LIM_BASE) && (reg_addr <= `TCLC_A_LIM_LAST);

  // Writable registers, limits stored raw in whatever format host wrote
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      rate_reg <= `TCLC_RATE_RST;
      cfg_reg  <= `TCLC_CFG_RST;
      hyst_reg <= `TCLC_HYST_RST;
      for (i = 0; i < 13; i = i + 1)
        lim[i] <= `TCLC_OT_RST;
      lim[`TCLC_L_LOC_HI] <= `TCLC_HI_RST;
      lim[`TCLC_L_LOC_LO] <= `TCLC_LO_RST;
      lim[`TCLC_L_R1_HI_L] <= `TCLC_LO_RST;
      lim[`TCLC_L_R1_LO_H] <= `TCLC_LO_RST;
      lim[`TCLC_L_R1_LO_L] <= `TCLC_LO_RST;
      lim[`TCLC_L_R2_HI_L] <= `TCLC_LO_RST;
      lim[`TCLC_L_R2_LO_H] <= `TCLC_LO_RST;
      lim[`TCLC_L_R2_LO_L] <= `TCLC_LO_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TCLC_A_RATE_WR)
        rate_reg <= reg_wdata;
      else if (reg_addr == `TCLC_A_CFG_WR)
        cfg_reg <= reg_wdata;
      else if (reg_addr == `TCLC_A_HYST)
        hyst_reg <= reg_wdata;
      else if (lim_hit)
        lim[lim_idx] <= reg_wdata;
    end
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clock)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `TCLC_A_RATE_RD)
        reg_rdata <= rate_reg;
      else if (reg_addr == `TCLC_A_CFG_RD)
        reg_rdata <= cfg_reg;
      else if (reg_addr == `TCLC_A_HYST)
        reg_rdata <= hyst_reg;
      else if (lim_hit)
        reg_rdata <= lim[lim_idx];
      else if (reg_addr == `TCLC_A_LOC_TEMP)
        reg_rdata <= meas[`TCLC_CH_LOCAL][15:8];
      else if (reg_addr == `TCLC_A_R1_TEMP_HI)
        reg_rdata <= meas[`TCLC_CH_R1][15:8];
      else if (reg_addr == `TCLC_A_R1_TEMP_LO)
        reg_rdata <= meas[`TCLC_CH_R1][7:0];
      else if (reg_addr == `TCLC_A_R2_TEMP_HI)
        reg_rdata <= meas[`TCLC_CH_R2][15:8];
      else if (reg_addr == `TCLC_A_R2_TEMP_LO)
        reg_rdata <= meas[`TCLC_CH_R2][7:0];
      else
        reg_rdata <= 8'h00;
    end
  end

  assign shared_pin_function_select = cfg_reg[`TCLC_CFG_PIN_SEL];
  assign adc_extended_range         = cfg_reg[`TCLC_CFG_RANGE];

  ////////////////////////////////////////////////////////////////////////////
  // Interval timing: base tick is the code ten interval
  assign tick         = (pre_cnt == TICK_CYCLES - 1);
  assign ticks_per_iv = 10'h001 << (`TCLC_CODE_FASTEST - act_code);
  assign boundary     = tick && (tick_cnt == ticks_per_iv - 10'h001);
  assign cont_mode    = (act_code >= `TCLC_CODE_CONT);

  // Prescaler and tick counter; settings latched at a boundary, or in continuous mode whenever the sequencer is idle
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      pre_cnt     <= 32'h0000_0000;
      tick_cnt    <= 10'h000;
      act_code    <= `TCLC_CODE_RST;
      act_sel     <= `TCLC_SEL_ALL;
      act_avg_off <= 1'b0;
    end
    else
    begin
      pre_cnt <= tick ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
      if (boundary || (cont_mode && state == ST_IDLE))
      begin
        tick_cnt    <= 10'h000;
        act_code    <= rate_reg[`TCLC_RATE_CODE_HI:0];
        act_sel     <= rate_reg[`TCLC_RATE_CH_HI:`TCLC_RATE_CH_LO];
        act_avg_off <= rate_reg[`TCLC_RATE_AVG_OFF];
      end
      else if (tick)
        tick_cnt <= tick_cnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      state       <= ST_IDLE;
      cur_ch      <= `TCLC_CH_LOCAL;
      adc_start   <= 1'b0;
      adc_channel <= `TCLC_CH_LOCAL;
      adc_average <= 1'b0;
      conv_busy   <= 1'b0;
    end
    else
    begin
      adc_start <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          conv_busy <= 1'b0;
          if (boundary || cont_mode)
          begin
            state     <= ST_REQ;
            conv_busy <= 1'b1;
            if (act_sel == `TCLC_SEL_ALL)
              cur_ch <= `TCLC_CH_LOCAL;
            else
              cur_ch <= act_sel - 2'h1;
          end
        end
        ST_REQ:
        begin
          adc_start   <= 1'b1;
          adc_channel <= cur_ch;
          adc_average <= !act_avg_off &&
                         !(act_code >= `TCLC_CODE_NO_AVG && act_code <= `TCLC_CODE_FASTEST);
          state       <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (adc_done)
          begin
            if (act_sel == `TCLC_SEL_ALL && cur_ch != `TCLC_CH_R2)
            begin
              cur_ch <= cur_ch + 2'h1;
              state  <= ST_REQ;
            end
            else
              state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparison on each finished result
  function [15:0] hi_lim;
    input [1:0] ch;
    begin
      if (ch == `TCLC_CH_LOCAL)
        hi_lim = {lim[`TCLC_L_LOC_HI], 8'h00};
      else if (ch == `TCLC_CH_R1)
        hi_lim = {lim[`TCLC_L_R1_HI_H], lim[`TCLC_L_R1_HI_L]};
      else
        hi_lim = {lim[`TCLC_L_R2_HI_H], lim[`TCLC_L_R2_HI_L]};
    end
  endfunction

  function [15:0] lo_lim;
    input [1:0] ch;
    begin
      if (ch == `TCLC_CH_LOCAL)
        lo_lim = {lim[`TCLC_L_LOC_LO], 8'h00};
      else if (ch == `TCLC_CH_R1)
        lo_lim = {lim[`TCLC_L_R1_LO_H], lim[`TCLC_L_R1_LO_L]};
      else
        lo_lim = {lim[`TCLC_L_R2_LO_H], lim[`TCLC_L_R2_LO_L]};
    end
  endfunction

  function [7:0] ot_lim;
    input [1:0] ch;
    begin
      if (ch == `TCLC_CH_LOCAL)
        ot_lim = lim[`TCLC_L_LOC_OT];
      else if (ch == `TCLC_CH_R1)
        ot_lim = lim[`TCLC_L_R1_OT];
      else
        ot_lim = lim[`TCLC_L_R2_OT];
    end
  endfunction

  // Store result, update flags and hysteresis comparators of that channel
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      for (j = 0; j < 3; j = j + 1)
        meas[j] <= 16'h0000;
      high_flags <= 3'h0;
      low_flags  <= 3'h0;
      ot_state   <= 3'h0;
      ot2_state  <= 3'h0;
    end
    else if (state == ST_WAIT && adc_done)
    begin
      meas[cur_ch] <= (cur_ch == `TCLC_CH_LOCAL) ? {adc_result[15:8], 8'h00} : adc_result;
      high_flags[cur_ch] <= (adc_result[15:8] > hi_lim(cur_ch) >> 8) ||
                            (cur_ch != `TCLC_CH_LOCAL && adc_result > hi_lim(cur_ch));
      low_flags[cur_ch]  <= (cur_ch == `TCLC_CH_LOCAL) ?
                            (adc_result[15:8] <= lo_lim(cur_ch) >> 8) :
                            (adc_result <= lo_lim(cur_ch));
      if (adc_result[15:8] > ot_lim(cur_ch))
        ot_state[cur_ch] <= 1'b1;
      else if ({1'b0, adc_result[15:8]} + {1'b0, hyst_reg} < {1'b0, ot_lim(cur_ch)})
        ot_state[cur_ch] <= 1'b0;
      if (adc_result[15:8] > hi_lim(cur_ch) >> 8)
        ot2_state[cur_ch] <= 1'b1;
      else if ({1'b0, adc_result[15:8]} + {1'b0, hyst_reg} < {1'b0, hi_lim(cur_ch) >> 8})
        ot2_state[cur_ch] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins
  assign overtemp_out_n = ~|ot_state;
  assign second_overtemp_out_n = shared_pin_function_select ?
                                 ~|ot2_state :
                                 ~|(high_flags | low_flags);

endmodule // tclc_conversion_limit_control

// ---- sim/tclc_checker_asserts.sv ----
// Port checker for the conversion and limit control block
`timescale 1ns/100ps
module tclc_checker
#(
  parameter TICK_CYCLES = 20
)
(
  input wire        clock,
  input wire        nrst,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire [7:0]  reg_wdata,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        adc_start,
  input wire [1:0]  adc_channel,
  input wire        adc_done,
  input wire [15:0] adc_result,
  input wire        conv_busy,
  input wire [2:0]  high_flags,
  input wire [2:0]  low_flags,
  input wire        overtemp_out_n,
  input wire        second_overtemp_out_n,
  input wire        shared_pin_function_select
);
  reg  [7:0] rate;
  reg  [7:0] hyst;
  reg  [7:0] hi;
  reg  [7:0] lo;
  wire [7:0] res = adc_result[15:8];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Shadow copies of host writes
  always @(posedge clock)
  begin
    rate <= !nrst ? 8'h08 : (reg_wr && reg_addr == 8'h0A) ? reg_wdata : rate;
    hyst <= !nrst ? 8'h0A : (reg_wr && reg_addr == 8'h4D) ? reg_wdata : hyst;
    hi <= !nrst ? 8'h7F : (reg_wr && reg_addr == 8'h40) ? reg_wdata : hi;
    lo <= !nrst ? 8'h00 : (reg_wr && reg_addr == 8'h41) ? reg_wdata : lo;
  end
  sequence s_loc_done;
    adc_done && conv_busy && adc_channel == 2'h0;
  endsequence
  sequence s_start_ok;
    $past(conv_busy) ##1 !adc_start;
  endsequence
  property p_start_pulse;
    adc_start |-> s_start_ok;
  endproperty
  property p_chan_hold;
    $changed(adc_channel) |-> adc_start;
  endproperty
  property p_rate_read;
    reg_rd && !reg_wr && reg_addr == 8'h04 |=> reg_rdata == $past(rate);
  endproperty
  property p_hyst_read;
    reg_rd && !reg_wr && reg_addr == 8'h4D |=> reg_rdata == $past(hyst);
  endproperty
  property p_high_flag;
    s_loc_done |=> high_flags[0] == ($past(res) > $past(hi));
  endproperty
  property p_low_flag;
    s_loc_done |=> low_flags[0] == ($past(res) <= $past(lo));
  endproperty
  property p_ot_cause;
    $fell(overtemp_out_n) |-> $past(adc_done);
  endproperty
  property p_alert_level;
    !shared_pin_function_select |-> second_overtemp_out_n == ~|{high_flags, low_flags};
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("bad start");
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  a_rate_read: assert property (p_rate_read) else $error("rate read");
  a_hyst_read: assert property (p_hyst_read) else $error("hyst read");
  a_high_flag: assert property (p_high_flag) else $error("high flag");
  a_low_flag: assert property (p_low_flag) else $error("low flag");
  a_ot_cause: assert property (p_ot_cause) else $error("overtemp cause");
  a_alert_level: assert property (p_alert_level) else $error("alert level");
endmodule // tclc_checker
bind tclc_conversion_limit_control tclc_checker #(.TICK_CYCLES(TICK_CYCLES)) tclc_checker_i
(
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done),
  .adc_result(adc_result), .conv_busy(conv_busy), .high_flags(high_flags),
  .low_flags(low_flags), .overtemp_out_n(overtemp_out_n),
  .second_overtemp_out_n(second_overtemp_out_n),
  .shared_pin_function_select(shared_pin_function_select)
);

// ---- sim/tclc_adc_model.sv ----
// Behavioural converter answering start pulses
`timescale 1ns/100ps
module tclc_adc_model
(
  input  wire        clock,
  input  wire        adc_start,
  input  wire [1:0]  adc_channel,
  input  wire [7:0]  lat,
  output reg         adc_done,
  output reg  [15:0] adc_result
);
  reg [15:0] temp [0:2];
  reg [1:0]  ch;
  ////////////////////////////////////////
  // Result valid only with done, inverted after
  always @(posedge clock)
    if (adc_start)
    begin
      ch = adc_channel;
      repeat (lat) @(negedge clock);
      adc_result <= temp[ch];
      adc_done <= 1'b1;
      @(negedge clock);
      adc_done <= 1'b0;
      adc_result <= ~temp[ch];
    end
  initial
  begin
    adc_done = 1'b0;
    adc_result = 16'h0000;
  end
endmodule // tclc_adc_model

// ---- sim/tclc_conversion_limit_control_test.sv ----
// Self-checking bench for the conversion and limit control block
`timescale 1ns/100ps
module tclc_conversion_limit_control_test;
  localparam TICK = 20;
  reg         clock, nrst, reg_wr, reg_rd, ot_s, h2_s, cfg_th;
  reg  [7:0]  reg_addr, reg_wdata, lat, v, hi, lo, ot, hy;
  wire [7:0]  reg_rdata;
  wire        adc_start, adc_average, adc_ext, adc_done, conv_busy, ot_n, ot2_n, pin_sel;
  wire [1:0]  adc_channel;
  wire [15:0] adc_result;
  wire [2:0]  high_flags, low_flags;
  integer     seed, error_cnt, compares, i, j, k, n;
  tclc_conversion_limit_control #(.TICK_CYCLES(TICK)) tclc_conversion_limit_control_i
  (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_average(adc_average),
    .adc_extended_range(adc_ext), .adc_done(adc_done), .adc_result(adc_result),
    .conv_busy(conv_busy), .high_flags(high_flags), .low_flags(low_flags),
    .overtemp_out_n(ot_n), .second_overtemp_out_n(ot2_n),
    .shared_pin_function_select(pin_sel)
  );
  tclc_adc_model tclc_adc_model_i
  (
    .clock(clock), .adc_start(adc_start), .adc_channel(adc_channel), .lat(lat),
    .adc_done(adc_done), .adc_result(adc_result)
  );
  ////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    #2000000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
  task chk(input [15:0] got, input [15:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  end
  endtask
  task wait_start;
  begin
    n = 1;
    @(negedge clock);
    while (adc_start !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n = n + 1;
    end
    if (n >= 2000)
      chk(0, 1);
  end
  endtask
  function [1:0] chan_exp(input [1:0] s, input [1:0] c);
    chan_exp = (s == 2'h0) ? c : s - 2'h1;
  endfunction
  // Expected flags and pins, tracking both hysteresis states
  function [3:0] expect4(input [7:0] x);
  begin
    if (x > ot)
      ot_s = 1'b1;
    else if ({1'b0, x} + hy < ot)
      ot_s = 1'b0;
    if (x > hi)
      h2_s = 1'b1;
    else if ({1'b0, x} + hy < hi)
      h2_s = 1'b0;
    expect4 = {x > hi, x <= lo, ~ot_s, cfg_th ? ~h2_s : ~(x > hi || x <= lo)};
  end
  endfunction
  task step(input [7:0] x);
  begin
    tclc_adc_model_i.temp[0] = {x, 8'h00};
    wait_start;
    wait_start;
    chk({high_flags[0], low_flags[0], ot_n, ot2_n}, expect4(x));
  end
  endtask
  task wrap_up;
  begin
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 53239;
    error_cnt = 0;
    compares = 0;
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, ot_s, h2_s, cfg_th} = 0;
    lat = 8'h02;
    for (i = 0; i < 3; i = i + 1)
      tclc_adc_model_i.temp[i] = 16'h1900;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    rd(8'h04, 8'h08);
    rd(8'h4D, 8'h0A);
    rd(8'h40, 8'h7F);
    rd(8'hFF, 8'h00);
    $display("reset values done");
    for (i = 0; i < 14; i = i + 1)
    begin
      v = $random(seed);
      wr(8'h40 + i[7:0], v);
      rd(8'h40 + i[7:0], v);
    end
    v = ($random(seed) & 8'hB3) | 8'h08;
    wr(8'h0A, v);
    rd(8'h04, v);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    rd(8'h04, 8'h08);
    $display("readback done");
    for (i = 0; i < 8; i = i + 1)
    begin
      v = $random(seed);
      v = {v[7], 1'b0, i[1:0], i[2] ? 4'hB : 4'hA};
      wr(8'h0A, v);
      lat = 8'h01 + ($random(seed) & 8'h07);
      for (j = 0; j < 4; j = j + 1)
        wait_start;
      for (k = 0; k < 4 && adc_channel !== chan_exp(i[1:0], 0); k = k + 1)
        wait_start;
      for (j = 0; j < 3; j = j + 1)
      begin
        if (j > 0)
          wait_start;
        chk({adc_channel, adc_average}, {chan_exp(i[1:0], j[1:0]), ~v[7] & i[2]});
      end
    end
    $display("channel select done");
    for (i = 6; i < 11; i = i + 1)
    begin
      wr(8'h0A, {4'h9, i[3:0]});
      for (j = 0; j < 4; j = j + 1)
        wait_start;
      chk(n, TICK << (10 - i));
      // Between sets the sequencer must fall idle
      if (i < 10)
      begin
        repeat (30) @(negedge clock);
        chk(conv_busy, 0);
      end
    end
    $display("interval done");
    wr(8'h0A, 8'h9A);
    hi = 8'h50;
    lo = 8'h0A;
    ot = 8'h5A;
    hy = 8'h01 + ($random(seed) & 8'h07);
    wr(8'h40, hi);
    wr(8'h41, lo);
    wr(8'h42, ot);
    wr(8'h4D, hy);
    cfg_th = 1'b1;
    wr(8'h09, 8'h20);
    chk(pin_sel, 1);
    step(8'h51);
    step(8'h50);
    step(hi - hy - 8'h01);
    step(8'h5B);
    step(ot - hy);
    step(ot - hy - 8'h01);
    step(lo);
    for (i = 0; i < 10; i = i + 1)
      step(8'h40 + ($random(seed) & 8'h1F));
    cfg_th = 1'b0;
    wr(8'h09, 8'h04);
    chk({pin_sel, adc_ext}, 2'b01);
    step(lo);
    lo = 8'h4A;
    wr(8'h41, lo);
    step(8'h4A);
    step(8'h4B);
    // First remote only, two-byte high limit decided by the fraction byte
    wr(8'h0A, 8'hAA);
    wr(8'h43, 8'h50);
    wr(8'h44, 8'h40);
    tclc_adc_model_i.temp[1] = 16'h5040;
    for (j = 0; j < 3; j = j + 1)
      wait_start;
    chk({conv_busy, high_flags[1], low_flags[1], ot2_n}, 4'b1001);
    tclc_adc_model_i.temp[1] = 16'h5041;
    wait_start;
    wait_start;
    chk({conv_busy, high_flags[1], low_flags[1], ot2_n}, 4'b1100);
    $display("limits done");
    wrap_up;
  end
endmodule // tclc_conversion_limit_control_test
